// ===== logic/clkwait_pkg.sv
/*
 Constants shared by the clock generator and stall controller: register map,
 field positions, reset values, cycle counts and state codes.
 Assumes the single system clock stands in for the oscillator.
*/
`default_nettype none
package clkwait_pkg;
   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_STATUS    = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h0c;
   // Decoded register index; IDX_NONE marks an unmapped address
   localparam logic [2:0] IDX_CTRL      = 3'h0;
   localparam logic [2:0] IDX_STATUS    = 3'h1;
   localparam logic [2:0] IDX_IRQ_STAT  = 3'h2;
   localparam logic [2:0] IDX_IRQ_MASK  = 3'h3;
   localparam logic [2:0] IDX_NONE      = 3'h4;
   // Control register fields
   localparam int         CTRL_RUN_BIT  = 0;
   localparam int         CTRL_STEP_BIT = 1;
   localparam int         CTRL_CLR_BIT  = 2;
   localparam int         CTRL_TMO_BIT  = 3;
   localparam logic       RUN_RESET     = 1'b1;
   localparam logic       TMO_RESET     = 1'b0;
   // Status register fields
   localparam int         STAT_WAIT_BIT = 0;
   localparam int         STAT_EXP_BIT  = 1;
   localparam int         STAT_MODE_LSB = 2;
   localparam int         STAT_DIV_LSB  = 8;
   // Interrupt status / mask layout
   localparam int         IRQ_EXP_BIT   = 0;
   localparam int         IRQ_STEP_BIT  = 1;
   localparam int         IRQ_REQ_BIT   = 2;
   localparam logic [2:0] IRQ_RESET     = 3'h0;
   // Divider taps: oscillator / 4, / 8, / 16
   localparam int         CPU_TAP       = 1;
   localparam int         PER2_TAP      = 2;
   localparam int         PER1_TAP      = 3;
   // Ready expiry limit and single-step bus cycle, in oscillator clocks
   localparam logic [4:0] EXP_CLKS      = 5'h10;
   localparam logic [3:0] STEP_CLKS     = 4'hc;
   // Processor status codes {code_3, code_2, code_1} that disable expiry
   localparam logic [2:0] CODE_INTERNAL = 3'h0;
   localparam logic [2:0] CODE_REFRESH  = 3'h1;

   typedef enum logic [2:0] {
      M_RUN  = 3'b001,
      M_HALT = 3'b010,
      M_STEP = 3'b100
   } mode_t;

   typedef struct packed {
      mode_t       mode;
      logic [3:0]  step_cnt;
      logic [3:0]  div_cnt;
      logic [4:0]  exp_cnt;
      logic        expiry;
      logic        req_prev;
      logic        wait_n;
      logic        osc_on;
      logic        run;
      logic        tmo_en;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic        irq;
      logic        wr_pend;
      logic [2:0]  wr_idx;
      logic [31:0] rdata;
   } state_t;
endpackage
`default_nettype wire

// ===== logic/clock_gen_wait_controller.sv
/*
 Clock divider and processor stall controller with an AHB-Lite register slave
 and one level interrupt.
 Assumes clk stands for the oscillator; divided clocks are flop outputs and
 all inputs are synchronous to clk.
*/
//Contract
//[RL1] Processor clock is the oscillator divided by four.
//[RL2] Peripheral clocks at oscillator/8 and /16, aligned with other outputs.
//[RL3] Buffered full-rate oscillator copy is provided; osc_tick is instead a flop held high from the first clock after reset.
//[RL4] Extra logic-level clock runs in step with the processor clock.
//[RL5] Divider counters can be cleared to realign all divided clocks.
//[RL6] Stall request combines run/stop, step and peripheral ready.
//[RL7] Halt holds stall output low so processor keeps stalling.
//[RL8] Peripheral ready low requests stall; passed through to stall output.
//[RL9] Enabled expiry forces expiry and stall output high 16 clocks after request.
//[RL10] Status codes for internal operation and refresh suspend expiry counting.
//[RL11] Step while halted releases stall for one bus cycle, then halts again.
//[RL12] Expiry count restarts per request; expiry clears when request released.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_wait_controller
   import clkwait_pkg::*;
(
   input  wire logic        clk,               // system clock (oscillator)
   input  wire logic        reset,             // async reset, active high
   input  wire logic        hsel,              // AHB slave select
   input  wire logic [31:0] haddr,             // AHB address
   input  wire logic [1:0]  htrans,            // AHB transfer type
   input  wire logic        hwrite,            // AHB write
   input  wire logic [2:0]  hsize,             // AHB size (word only)
   input  wire logic [31:0] hwdata,            // AHB write data
   input  wire logic        hready,            // AHB bus ready
   output logic             hreadyout,         // AHB slave ready
   output logic             hresp,             // AHB response, always OKAY
   output logic [31:0]      hrdata,            // AHB read data
   input  wire logic        periph_ready,      // low: peripheral asks for stall
   input  wire logic        cpu_status_code_1, // processor status line 1
   input  wire logic        cpu_status_code_2, // processor status line 2
   input  wire logic        cpu_status_code_3, // processor status line 3
   output logic             osc_tick,          // held high by osc_on from the first clock after reset
   output logic             cpu_clk,           // oscillator / 4
   output logic             cpu_clk_ttl,       // logic-level copy of cpu_clk
   output logic             per_clk_2m,        // oscillator / 8
   output logic             per_clk_1m,        // oscillator / 16
   output logic             cpu_wait_n,        // low: processor inserts stall_cycle
   output logic             timeout_out,       // ready expiry reached
   output logic             irq                // level interrupt
);
   state_t     st;
   state_t     n;
   logic       acc;
   logic       wr_ctrl;
   logic       clr_ev;
   logic       req;
   logic       supp;
   logic       counting;
   logic       step_go;
   logic [2:0] ev;
   logic [2:0] w1c;

   function automatic logic [2:0] reg_index(input logic [31:0] a);
      logic [2:0] r;
      r = IDX_NONE;
      if (a[31:8] == 24'h000000) begin
         case (a[7:0])
            OFF_CTRL:     r = IDX_CTRL;
            OFF_STATUS:   r = IDX_STATUS;
            OFF_IRQ_STAT: r = IDX_IRQ_STAT;
            OFF_IRQ_MASK: r = IDX_IRQ_MASK;
            default:      r = IDX_NONE;
         endcase
      end
      return r;
   endfunction

   // Internal operations and refresh are not peripheral waits
   function automatic logic expiry_suppressed(input logic [2:0] code);
      return (code == CODE_INTERNAL) || (code == CODE_REFRESH);
   endfunction

   always_comb begin
      n        = st;
      ev       = 3'h0;
      acc      = hsel && htrans[1] && hready;
      wr_ctrl  = st.wr_pend && (st.wr_idx == IDX_CTRL);
      w1c      = (st.wr_pend && st.wr_idx == IDX_IRQ_STAT) ? hwdata[2:0] : 3'h0;
      clr_ev   = wr_ctrl && hwdata[CTRL_CLR_BIT];
      req      = !periph_ready;
      supp     = expiry_suppressed({cpu_status_code_3, cpu_status_code_2,
                                    cpu_status_code_1});
      counting = req && st.tmo_en && !supp;
      step_go  = 1'b0;

      // Register writes land in the data phase
      if (wr_ctrl) begin
         n.run    = hwdata[CTRL_RUN_BIT];
         n.tmo_en = hwdata[CTRL_TMO_BIT];
      end
      if (st.wr_pend && st.wr_idx == IDX_IRQ_MASK) begin
         n.irq_mask = hwdata[2:0];
      end

      // One counter feeds every divided clock, so all edges share a phase
      n.osc_on  = 1'b1;                                          // RL3
      n.div_cnt = clr_ev ? 4'h0 : st.div_cnt + 4'h1;             // RL1 RL2 RL5

      // Ready expiry counter
      n.req_prev = req;
      if (!req) begin
         n.exp_cnt = 5'h00;                                      // RL12
      end else if (!st.req_prev) begin
         n.exp_cnt = counting ? 5'h01 : 5'h00;                   // RL12
         ev[IRQ_REQ_BIT] = 1'b1;
      end else if (counting && st.exp_cnt != EXP_CLKS) begin
         n.exp_cnt = st.exp_cnt + 5'h01;                         // RL10
      end
      n.expiry = (n.exp_cnt == EXP_CLKS) && st.tmo_en;           // RL9
      ev[IRQ_EXP_BIT] = n.expiry && !st.expiry;

      // Run, halt and single step; a run written mid-step waits for its end
      case (st.mode)
         M_RUN: begin
            if (!n.run) begin
               n.mode = M_HALT;
            end
         end
         M_HALT: begin
            if (n.run) begin
               n.mode = M_RUN;
            end else if (wr_ctrl && hwdata[CTRL_STEP_BIT]) begin
               step_go    = 1'b1;
               n.mode     = M_STEP;                              // RL11
               n.step_cnt = STEP_CLKS - 4'h1;
            end
         end
         M_STEP: begin
            if (st.step_cnt == 4'h0) begin
               n.mode = M_HALT;                                  // RL11
               ev[IRQ_STEP_BIT] = 1'b1;
            end else begin
               n.step_cnt = st.step_cnt - 4'h1;
            end
         end
         default: begin
            n.mode = M_HALT;
         end
      endcase

      // Halt forces a stall; otherwise ready, relieved by expiry, decides
      n.wait_n = (n.mode != M_HALT) && (periph_ready || n.expiry); // RL6 RL7 RL8 RL9

      // Hardware event wins over a same-cycle write-one-to-clear
      n.irq_stat = (st.irq_stat & ~w1c) | ev;
      n.irq      = |(n.irq_stat & n.irq_mask);

      // Address phase: latch write target, fetch read word for data phase
      n.wr_pend = acc && hwrite;
      n.wr_idx  = reg_index(haddr);
      if (acc && !hwrite) begin
         case (reg_index(haddr))
            IDX_CTRL: begin
               n.rdata = 32'h0;
               n.rdata[CTRL_RUN_BIT] = st.run;
               n.rdata[CTRL_TMO_BIT] = st.tmo_en;
            end
            IDX_STATUS: begin
               n.rdata = 32'h0;
               n.rdata[STAT_WAIT_BIT] = st.wait_n;
               n.rdata[STAT_EXP_BIT]  = st.expiry;
               n.rdata[STAT_MODE_LSB +: 3] = st.mode;
               n.rdata[STAT_DIV_LSB +: 4]  = st.div_cnt;
            end
            IDX_IRQ_STAT: n.rdata = {29'h0, st.irq_stat};
            IDX_IRQ_MASK: n.rdata = {29'h0, st.irq_mask};
            default:      n.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st          <= '0;
         st.mode     <= M_RUN;
         st.run      <= RUN_RESET;
         st.tmo_en   <= TMO_RESET;
         st.irq_stat <= IRQ_RESET;
         st.irq_mask <= IRQ_RESET;
         st.wr_idx   <= IDX_NONE;
      end else begin
         st <= n;
      end
   end

   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign hrdata      = st.rdata;
   assign osc_tick    = st.osc_on;
   assign cpu_clk     = st.div_cnt[CPU_TAP];
   assign cpu_clk_ttl = st.div_cnt[CPU_TAP];                     // RL4
   assign per_clk_2m  = st.div_cnt[PER2_TAP];
   assign per_clk_1m  = st.div_cnt[PER1_TAP];
   assign cpu_wait_n  = st.wait_n;
   assign timeout_out = st.expiry;
   assign irq         = st.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence req_start_s;
      req && !st.req_prev && st.tmo_en && !supp && st.mode == M_RUN && !wr_ctrl;
   endsequence
   sequence req_held_s;
      req && st.tmo_en && !supp && st.mode == M_RUN && !wr_ctrl;
   endsequence

   cpu_divide_a: assert property (                               // RL1
      ($rose(cpu_clk) && !clr_ev) ##1 (!clr_ev)[*3] |=> $rose(cpu_clk))
      else $error("processor clock is not oscillator divided by four");
   per_align_a: assert property (                                // RL2
      $rose(per_clk_1m) |-> !per_clk_2m && !cpu_clk && $fell(per_clk_2m))
      else $error("peripheral clocks out of phase");
   osc_copy_a: assert property (!$past(reset) |-> osc_tick)      // RL3
      else $error("oscillator copy not running");
   ttl_step_a: assert property (cpu_clk_ttl == cpu_clk && $stable(cpu_clk_ttl ^ cpu_clk)) // RL4
      else $error("logic-level clock out of step with processor clock");
   div_clear_a: assert property (                                // RL5
      clr_ev |=> !cpu_clk && !per_clk_2m && !per_clk_1m ##1 !cpu_clk)
      else $error("divider clear did not realign clocks");
   halt_wait_a: assert property (st.mode == M_HALT |-> !cpu_wait_n) // RL7
      else $error("stall output released while halted");
   ready_pass_a: assert property (                               // RL6
      (req && !st.tmo_en && !wr_ctrl && st.mode != M_STEP) |=> !cpu_wait_n)
      else $error("peripheral stall request not passed on");
   ready_free_a: assert property (                               // RL8
      (periph_ready && st.mode == M_RUN && !wr_ctrl) |=> cpu_wait_n)
      else $error("stall output low with ready high while running");
   expiry_hit_a: assert property (                               // RL9
      req_start_s ##1 req_held_s[*8] ##1 req_held_s[*7] |=> timeout_out && cpu_wait_n)
      else $error("expiry not reached 16 clocks after request");
   expiry_early_a: assert property (                             // RL9
      req_start_s ##1 req_held_s[*8] ##1 req_held_s[*6] |=> !timeout_out)
      else $error("expiry came before 16 clocks");
   suppress_a: assert property (                                 // RL10
      (req && st.req_prev && supp) |=> $stable(st.exp_cnt))
      else $error("expiry counted during internal operation or refresh");
   step_once_a: assert property (                                // RL11
      step_go |=> (st.mode == M_STEP)[*8] ##1 (st.mode == M_STEP)[*4]
                  ##1 (st.mode == M_HALT && !cpu_wait_n))
      else $error("step did not release for exactly one bus cycle");
   release_a: assert property (                                  // RL12
      (!req && st.req_prev) |=> st.exp_cnt == 5'h00 && !timeout_out)
      else $error("expiry not cleared after request release");

   // Clock phase checks; a divider clear may cut any period short
   sequence cpu_rise_s;
      $rose(cpu_clk) && !clr_ev;
   endsequence
   sequence per2_rise_s;
      $rose(per_clk_2m) && !clr_ev;
   endsequence

   cpu_high_a: assert property (cpu_rise_s |=> cpu_clk)          // RL1
      else $error("processor clock high phase too short");
   cpu_low_a: assert property ($fell(cpu_clk) |=> !cpu_clk)      // RL1
      else $error("processor clock low phase too short");
   div_count_a: assert property (                                // RL1
      !clr_ev |=> st.div_cnt == $past(st.div_cnt) + 4'h1)
      else $error("divider counter skipped a step");
   per2_high_a: assert property (                                // RL2
      per2_rise_s ##1 (!clr_ev)[*2] |=> per_clk_2m)
      else $error("peripheral clock high phase too short");
   per2_sync_a: assert property ($rose(per_clk_2m) |-> $fell(cpu_clk)) // RL2
      else $error("peripheral clock edge not aligned with processor clock");

   // Run, halt and step control
   halt_enter_a: assert property (                               // RL7
      (wr_ctrl && !hwdata[CTRL_RUN_BIT] && st.mode == M_RUN)
      |=> st.mode == M_HALT && !cpu_wait_n)
      else $error("run cleared but processor not halted");
   run_resume_a: assert property (                               // RL6
      (wr_ctrl && hwdata[CTRL_RUN_BIT] && st.mode == M_HALT) |=> st.mode == M_RUN)
      else $error("run set but halt not left");
   step_ignore_a: assert property (                              // RL11
      (wr_ctrl && hwdata[CTRL_STEP_BIT] && st.mode == M_RUN) |=> st.mode != M_STEP)
      else $error("step accepted while not halted");
   step_release_a: assert property ((step_go && periph_ready) |=> cpu_wait_n) // RL11
      else $error("single step did not release the stall output");

   // Expiry: the limit only relieves a stall, it never adds one
   expiry_stall_a: assert property ((timeout_out && st.mode != M_HALT) |-> cpu_wait_n) // RL9
      else $error("expiry reached but stall output still low");
   expiry_off_a: assert property (!$past(st.tmo_en) |-> !timeout_out) // RL9
      else $error("expiry reached with expiry disabled");
   expiry_irq_a: assert property ($rose(timeout_out) |-> st.irq_stat[IRQ_EXP_BIT]) // RL9
      else $error("expiry event not recorded");
   count_restart_a: assert property ((req && !st.req_prev) |=> st.exp_cnt <= 5'h01) // RL12
      else $error("expiry count did not restart on new request");
   suppress_zero_a: assert property (                            // RL10
      (req && !st.req_prev && supp) |=> st.exp_cnt == 5'h00)
      else $error("expiry counted from a suppressed request start");
endmodule
`default_nettype wire

// ===== sim/periph_model.sv
/*
 Peripheral that asks the controller for stall cycles.
 Assumes start is a one-clock pulse from the bench, synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module periph_model (
   input  wire logic       clk,          // system clock
   input  wire logic       reset,        // async reset, active high
   input  wire logic       start,        // begin one stall request
   input  wire logic [7:0] len,          // request length in clocks
   output logic            periph_ready  // low while a stall is requested
);
   logic [7:0] left_reg;

   // The request is held until the peripheral's own work is done
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         left_reg <= 8'h00;
      else if (start)
         left_reg <= len;
      else if (left_reg != 8'h00)
         left_reg <= left_reg - 8'h01;
   end

   assign periph_ready = (left_reg == 8'h00);
endmodule
`default_nettype wire

// ===== sim/tb_clock_gen_wait_controller.sv
/*
 Self-checking bench for the clock divider and stall controller.
 Assumes an AHB-Lite slave whose hreadyout is the bus ready, and periph_model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_clock_gen_wait_controller;
   import clkwait_pkg::*;
   logic        clk, reset, hsel, hwrite, hreadyout, hresp, start, irq;
   logic        periph_ready, osc_tick, cpu_clk, cpu_clk_ttl, per_clk_2m;
   logic        per_clk_1m, cpu_wait_n, timeout_out;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, code, prev;
   logic [7:0]  len;
   int          err_count, n_checks, n1, n2, n3, n4, n5, n6;
   // Rows: status code, expiry enable, expected expiry
   logic [4:0]  rows [4] = '{5'b01011, 5'b00010, 5'b00110, 5'b01000};

   clock_gen_wait_controller i_clock_gen_wait_controller (.clk, .reset, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
      .hresp, .hrdata, .periph_ready, .cpu_status_code_1(code[0]),
      .cpu_status_code_2(code[1]), .cpu_status_code_3(code[2]), .osc_tick,
      .cpu_clk, .cpu_clk_ttl, .per_clk_2m, .per_clk_1m, .cpu_wait_n,
      .timeout_out, .irq);
   periph_model i_periph_model (.clk, .reset, .start, .len, .periph_ready);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One single word transfer; waits for hready in both phases
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Whole run is under 1500 clocks
   initial begin
      #200000;
      err_count++;
      $display("watchdog expired");
      end_of_test();
   end

   initial begin
      reset = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      start = 1'b0;
      len = 8'h18;
      code = 3'h2;
      err_count = 0;
      n_checks = 0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      bus(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h1);
      chk(hresp, 1'b0);
      bus(1'b0, 32'h4, 32'h0);
      chk(rd & 32'hff, 32'h5);
      bus(1'b1, 32'h40, 32'hf);
      bus(1'b0, 32'h40, 32'h0);
      chk(rd, 32'h0);
      $display("reset and registers done");
      // Clear the divider, then count edges over four slow periods
      bus(1'b1, 32'h0, 32'h5);
      #1 chk({cpu_clk, per_clk_2m, per_clk_1m}, 32'h0);
      tick(2);
      chk(cpu_clk, 1'b1);
      prev = {cpu_clk, per_clk_2m, per_clk_1m};
      for (int i = 0; i < 64; i++) begin
         tick(1);
         n1 += (cpu_clk && !prev[2]);
         n2 += (per_clk_2m && !prev[1]);
         n3 += (per_clk_1m && !prev[0]);
         n4 += (per_clk_1m && !prev[0] && !per_clk_2m && prev[1] && !cpu_clk);
         n5 += (osc_tick === 1'b1);
         n6 += (cpu_clk_ttl !== cpu_clk);
         prev = {cpu_clk, per_clk_2m, per_clk_1m};
      end
      chk(n1, 16);
      chk(n2, 8);
      chk(n3, 4);
      chk(n4, 4);
      chk(n5, 64);
      chk(n6, 0);
      $display("divider done");
      foreach (rows[k]) begin
         bus(1'b1, 32'h0, rows[k][1] ? 32'h9 : 32'h1);
         code <= rows[k][4:2];
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
         tick(1);
         chk(cpu_wait_n, 1'b0);
         tick(14);
         chk(timeout_out, 1'b0);
         tick(1);
         chk(timeout_out, rows[k][0]);
         chk(cpu_wait_n, rows[k][0]);
         tick(10);
         chk(timeout_out, 1'b0);
         chk(cpu_wait_n, 1'b1);
         $display("stall row %0d done", k);
      end
      chk(irq, 1'b0);
      bus(1'b0, 32'h8, 32'h0);
      chk(rd, 32'h5);
      bus(1'b1, 32'hc, 32'h1);
      tick(2);
      chk(irq, 1'b1);
      bus(1'b1, 32'h8, 32'h5);
      tick(2);
      chk(irq, 1'b0);
      $display("interrupt done");
      bus(1'b1, 32'hc, 32'h2);
      bus(1'b1, 32'h0, 32'h0);
      #1 chk(cpu_wait_n, 1'b0);
      tick(6);
      chk(cpu_wait_n, 1'b0);
      bus(1'b1, 32'h0, 32'h2);
      n1 = 0;
      #1;
      for (int i = 0; i < 20; i++) begin
         n1 += (cpu_wait_n === 1'b1);
         tick(1);
      end
      chk(n1, STEP_CLKS);
      chk(irq, 1'b1);
      bus(1'b1, 32'h0, 32'h1);
      #1 chk(cpu_wait_n, 1'b1);
      $display("halt and step done");
      // Reset in mid-run must drop the clock, stall, expiry and interrupt outputs and restore the defaults
      bus(1'b1, 32'h0, 32'h9);
      reset <= 1'b1;
      tick(3);
      chk({osc_tick, cpu_wait_n, timeout_out, irq, cpu_clk}, 32'h0);
      @(posedge clk);
      reset <= 1'b0;
      #1 chk(osc_tick, 1'b0);
      tick(1);
      chk(osc_tick, 1'b1);
      chk(cpu_wait_n, 1'b1);
      bus(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h1);
      $display("reset in mid-run done");
      end_of_test();
   end
endmodule
`default_nettype wire
